//--- fidsr_core.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Two-entry buffer
// ****************************************
module fidsr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rp];
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wp <= '0;
         rp <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
         end
         if (pop) begin
            rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end
endmodule

module fidsr_core #(
   // Identity code defaults are arbitrary values
   parameter logic [7:0] MAKER_ID = 8'h5C,
   parameter logic [7:0] MEM_TYPE = 8'h33,
   parameter logic [7:0] CAPACITY = 8'h15,
   parameter logic [7:0] DEVICE_ID = 8'h14,
   parameter int ERASE_CYCLES = fidsr_pkg::ERASE_TIME_US * fidsr_pkg::CLK_MHZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins
   input wire fidsr_pkg::fidsr_pins_in_t pins_in,
   output fidsr_pkg::fidsr_pins_out_t pins_out,
   // Status register interface
   input wire logic write_enable_latch_bit,
   input wire logic [2:0] otp_lock_bits,
   input wire logic other_busy,
   output logic erase_busy,
   output logic latch_clear,
   // Parameter table lookup
   output logic [7:0] table_addr,
   input wire logic [7:0] table_data
);
   localparam int TW = $clog2(ERASE_CYCLES + 1);

   // ****************************************
   // Pin synchronisers and edge detection
   // ****************************************
   fidsr_pkg::fidsr_pins_in_t sync1;
   fidsr_pkg::fidsr_pins_in_t sync2;
   logic sclk_d;
   logic cs_d;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1 <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
         sync2 <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sync1 <= pins_in;
         sync2 <= sync1;
         sclk_d <= sync2.sclk;
         cs_d <= sync2.cs_n;
      end
   end
   wire cs_hi = sync2.cs_n;
   wire cs_rise = sync2.cs_n & ~cs_d;
   wire rise = ~cs_hi & sync2.sclk & ~sclk_d;
   wire fall = ~cs_hi & ~sync2.sclk & sclk_d;

   // ****************************************
   // Command decode
   // ****************************************
   fidsr_pkg::fidsr_state_t state;
   fidsr_pkg::fidsr_state_t next_state;
   logic [5:0] cnt;
   logic [2:0] bitpos;
   logic [31:0] sh;
   logic [7:0] opcode;
   logic [7:0] ptr;
   logic [1:0] reg_sel;
   logic [TW-1:0] timer;
   logic prog_wrote;

   wire is_dual = opcode == fidsr_pkg::OPC_ID_DUAL;
   wire is_quad = opcode == fidsr_pkg::OPC_ID_QUAD;
   wire in_opc = state == fidsr_pkg::ST_OPC;
   wire [3:0] lanes = in_opc ? fidsr_pkg::LANES_1 :
      is_quad ? fidsr_pkg::LANES_4 : is_dual ? fidsr_pkg::LANES_2 : fidsr_pkg::LANES_1;
   wire [31:0] next_sh = (lanes == fidsr_pkg::LANES_4) ? {sh[27:0], sync2.io} :
      (lanes == fidsr_pkg::LANES_2) ? {sh[29:0], sync2.io[1:0]} :
      {sh[30:0], sync2.io[0]};
   wire [7:0] new_opc = next_sh[7:0];
   // Dual and quad frames carry the mode byte below the address
   wire [23:0] addr24 = (is_dual | is_quad) ? next_sh[31:8] : next_sh[23:0];
   wire [5:0] addr_end = is_quad ? fidsr_pkg::CNT_ADDR_QUAD :
      is_dual ? fidsr_pkg::CNT_ADDR_DUAL : fidsr_pkg::CNT_ADDR_SINGLE;
   wire [5:0] out_start = is_quad ? fidsr_pkg::CNT_OUT_QUAD :
      is_dual ? fidsr_pkg::CNT_ADDR_DUAL :
      (opcode == fidsr_pkg::OPC_RD_IDENT) ? fidsr_pkg::CNT_OPC : fidsr_pkg::CNT_OUT_LONG;
   wire opc_done = cnt == fidsr_pkg::CNT_OPC - 6'h01;
   wire addr_done = cnt == addr_end - 6'h01;
   wire busy_any = erase_busy | other_busy;

   // Security register window decode
   wire mid1 = addr24[15:8] == fidsr_pkg::SEC_R1;
   wire mid2 = addr24[15:8] == fidsr_pkg::SEC_R2;
   wire mid3 = addr24[15:8] == fidsr_pkg::SEC_R3;
   wire reg_hit = (addr24[23:16] == fidsr_pkg::SEC_TOP) & (mid1 | mid2 | mid3);
   wire [1:0] dec_idx = mid3 ? 2'h2 : mid2 ? 2'h1 : 2'h0;
   wire dec_locked = otp_lock_bits[dec_idx];
   wire writable = reg_hit & ~dec_locked;

   always_comb begin
      next_state = state;
      case (state)
         fidsr_pkg::ST_OPC: begin
            if (opc_done) begin
               if (busy_any) begin
                  next_state = fidsr_pkg::ST_IGN;
               end else begin
                  case (new_opc)
                     fidsr_pkg::OPC_RD_IDENT: next_state = fidsr_pkg::ST_DATA;
                     fidsr_pkg::OPC_RD_TABLE, fidsr_pkg::OPC_SEC_READ,
                     fidsr_pkg::OPC_ID_DUAL, fidsr_pkg::OPC_ID_QUAD: begin
                        next_state = fidsr_pkg::ST_ADDR;
                     end
                     fidsr_pkg::OPC_SEC_ERASE, fidsr_pkg::OPC_SEC_PROG: begin
                        next_state = write_enable_latch_bit ? fidsr_pkg::ST_ADDR :
                           fidsr_pkg::ST_IGN;
                     end
                     default: next_state = fidsr_pkg::ST_IGN;
                  endcase
               end
            end
         end
         fidsr_pkg::ST_ADDR: begin
            if (addr_done) begin
               case (opcode)
                  fidsr_pkg::OPC_SEC_ERASE: begin
                     next_state = writable ? fidsr_pkg::ST_ERASE : fidsr_pkg::ST_IGN;
                  end
                  fidsr_pkg::OPC_SEC_PROG: begin
                     next_state = writable ? fidsr_pkg::ST_PROG : fidsr_pkg::ST_IGN;
                  end
                  default: next_state = fidsr_pkg::ST_DATA;
               endcase
            end
         end
         default: next_state = state;
      endcase
   end

   // Frame state advances only on serial rising edges
   always_ff @(posedge clk) begin
      if (rst || cs_hi) begin
         state <= fidsr_pkg::ST_OPC;
         cnt <= '0;
         bitpos <= '0;
         sh <= '0;
      end else if (rise) begin
         state <= next_state;
         cnt <= (cnt == fidsr_pkg::CNT_SAT) ? cnt : cnt + 6'h01;
         bitpos <= bitpos + 3'h1;
         sh <= next_sh;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         opcode <= '0;
      end else if (rise && in_opc && opc_done) begin
         opcode <= new_opc;
      end
   end

   // ****************************************
   // Byte fetch into the output buffer
   // ****************************************
   logic [7:0] sec_mem [fidsr_pkg::SEC_REGS * fidsr_pkg::SEC_BYTES];
   logic [7:0] fetch_byte;
   logic [7:0] next_ptr;
   logic fifo_ready;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic shift_load;
   wire fetch_en = (state == fidsr_pkg::ST_DATA) & ~cs_hi;
   wire push = fetch_en & fifo_ready;
   wire [9:0] mem_idx = {reg_sel, ptr};
   wire prog_byte = rise & (state == fidsr_pkg::ST_PROG) & (bitpos == 3'h7);
   wire id_second = ptr[0];

   always_comb begin
      next_ptr = ptr + 8'h01;
      case (opcode)
         fidsr_pkg::OPC_RD_IDENT: begin
            fetch_byte = (ptr == 8'h00) ? MAKER_ID : (ptr == 8'h01) ? MEM_TYPE : CAPACITY;
            next_ptr = (ptr == fidsr_pkg::IDENT_LAST) ? 8'h00 : ptr + 8'h01;
         end
         fidsr_pkg::OPC_RD_TABLE: fetch_byte = table_data;
         fidsr_pkg::OPC_SEC_READ: fetch_byte = sec_mem[mem_idx];
         fidsr_pkg::OPC_ID_DUAL, fidsr_pkg::OPC_ID_QUAD: begin
            fetch_byte = id_second ? DEVICE_ID : MAKER_ID;
         end
         default: fetch_byte = fidsr_pkg::ERASED;
      endcase
   end
   assign table_addr = ptr;

   always_ff @(posedge clk) begin
      if (rst) begin
         ptr <= '0;
         reg_sel <= '0;
      end else if (rise && in_opc) begin
         ptr <= '0;
      end else if (rise && state == fidsr_pkg::ST_ADDR && addr_done) begin
         ptr <= addr24[7:0];
         reg_sel <= dec_idx;
      end else if (push || prog_byte) begin
         ptr <= next_ptr;
      end
   end

   // Buffer absorbs the fetch latency so the shifter never waits on a byte
   fidsr_fifo #(.WIDTH(8), .DEPTH(2)) u_buf (
      .clk(clk),
      .rst(rst),
      .flush(cs_hi),
      .in_valid(fetch_en),
      .in_ready(fifo_ready),
      .in_data(fetch_byte),
      .out_valid(fifo_valid),
      .out_ready(shift_load),
      .out_data(fifo_data)
   );

   // ****************************************
   // Output shifter on serial falling edges
   // ****************************************
   logic [7:0] out_sh;
   logic [3:0] bits_left;
   wire out_active = (state == fidsr_pkg::ST_DATA) & (cnt >= out_start);
   wire [3:0] out_lanes = is_quad ? fidsr_pkg::LANES_4 :
      is_dual ? fidsr_pkg::LANES_2 : fidsr_pkg::LANES_1;
   assign shift_load = fall & out_active & (bits_left == 4'h0);
   wire [7:0] load_byte = fifo_valid ? fifo_data : fidsr_pkg::ERASED;
   wire [7:0] next_out = (bits_left == 4'h0) ? load_byte : (out_sh << out_lanes);
   wire [3:0] lane_io = is_quad ? next_out[7:4] :
      is_dual ? {2'b00, next_out[7:6]} : {2'b00, next_out[7], 1'b0};
   wire [3:0] lane_oe = is_quad ? fidsr_pkg::OE_4 :
      is_dual ? fidsr_pkg::OE_2 : fidsr_pkg::OE_1;

   always_ff @(posedge clk) begin
      if (rst || cs_hi) begin
         out_sh <= '0;
         bits_left <= '0;
         pins_out <= '0;
      end else if (fall && out_active) begin
         out_sh <= next_out;
         bits_left <= ((bits_left == 4'h0) ? fidsr_pkg::BYTE_BITS : bits_left) - out_lanes;
         pins_out.io <= lane_io;
         pins_out.oe <= lane_oe;
      end
   end

   // ****************************************
   // Erase timer and write-enable clearing
   // ****************************************
   wire erase_start = cs_rise & (state == fidsr_pkg::ST_ERASE) &
      (cnt == fidsr_pkg::CNT_ADDR_SINGLE);
   wire erase_end = erase_busy & (timer == '0);

   always_ff @(posedge clk) begin
      if (rst) begin
         erase_busy <= 1'b0;
         timer <= '0;
         latch_clear <= 1'b0;
         prog_wrote <= 1'b0;
      end else begin
         if (erase_start) begin
            erase_busy <= 1'b1;
            timer <= TW'(ERASE_CYCLES - 1);
         end else if (erase_end) begin
            erase_busy <= 1'b0;
         end else if (erase_busy) begin
            timer <= timer - TW'(1);
         end
         // A program frame that wrote a byte also drops the latch, as a page program would
         latch_clear <= erase_end | (cs_rise & (state == fidsr_pkg::ST_PROG) & prog_wrote);
         prog_wrote <= cs_hi ? 1'b0 : (prog_wrote | prog_byte);
      end
   end

   // Storage: programming can only clear bits, erase sets a whole register
   always_ff @(posedge clk) begin
      if (erase_end) begin
         for (int i = 0; i < fidsr_pkg::SEC_BYTES; i++) begin
            sec_mem[{reg_sel, i[7:0]}] <= fidsr_pkg::ERASED;
         end
      end else if (prog_byte) begin
         sec_mem[mem_idx] <= sec_mem[mem_idx] & next_sh[7:0];
      end
   end
endmodule
`default_nettype wire

//--- fidsr_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker for the command core
// ****************************************
module fidsr_core_assertions #(
   parameter int ERASE_CYCLES = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins
   input wire fidsr_pkg::fidsr_pins_in_t pins_in,
   input wire fidsr_pkg::fidsr_pins_out_t pins_out,
   // Status
   input wire logic write_enable_latch_bit,
   input wire logic [2:0] otp_lock_bits,
   input wire logic other_busy,
   input wire logic erase_busy,
   input wire logic latch_clear,
   // Table
   input wire logic [7:0] table_addr,
   input wire logic [7:0] table_data
);
   logic [15:0] busy_cnt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Counts how long the erase timer held busy
   always_ff @(posedge clk) begin
      if (rst || !erase_busy) begin
         busy_cnt <= 16'h0000;
      end else begin
         busy_cnt <= busy_cnt + 16'h0001;
      end
   end

   a_oe_idle: assert property (pins_in.cs_n [*4] |-> pins_out.oe == 4'h0)
      else $error("output enable active with chip select high");
   a_oe_lanes: assert property (pins_out.oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("output enable pattern outside lane sets");
   a_busy_quiet: assert property (erase_busy |-> pins_out.oe == 4'h0)
      else $error("output driven during erase");
   a_erase_latch: assert property ($rose(erase_busy) |-> write_enable_latch_bit)
      else $error("erase started without write enable");
   a_busy_len: assert property ($fell(erase_busy) |-> busy_cnt == 16'(ERASE_CYCLES))
      else $error("erase busy length wrong");
   a_latch_after: assert property ($fell(erase_busy) |-> ##[0:1] latch_clear)
      else $error("no latch clear after erase");
   a_latch_pulse: assert property (latch_clear |=> !latch_clear)
      else $error("latch clear longer than one cycle");
   a_out_fall: assert property ($changed(pins_out.io) && $past(pins_out.oe) != 4'h0
      && pins_out.oe != 4'h0 |-> !$past(pins_in.sclk, 2))
      else $error("output changed away from a falling serial clock");
endmodule
`default_nettype wire

//--- fidsr_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module fidsr_core_tb_top;
   localparam int ERASE_CYCLES = 400;
   // Identity values are arbitrary
   localparam logic [7:0] MAKER = 8'hA7;
   localparam logic [7:0] MTYPE = 8'h3E;
   localparam logic [7:0] CAP = 8'h19;
   localparam logic [7:0] DEV = 8'h62;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic we_latch = 1'b0;
   logic [2:0] locks = 3'h0;
   logic other_busy = 1'b0;
   logic oe_seen = 1'b0;
   fidsr_pkg::fidsr_pins_in_t pins_in;
   fidsr_pkg::fidsr_pins_out_t pins_out;
   logic erase_busy, latch_clear, rx_stb;
   logic [7:0] table_addr, table_data, rx_byte;
   logic [7:0] expq[$];
   logic [31:0] seed = 32'h00013985;
   int n_mismatch = 0;
   int comparisons = 0;

   always #2 clk = ~clk;
   // Far-side parameter table: a fixed scramble of the index
   function automatic logic [7:0] tbl(input logic [7:0] x);
      return {x[3:0], x[7:4]} ^ 8'h3C;
   endfunction
   assign table_data = tbl(table_addr);
   // Status logic side: the core only requests the clear
   always @(negedge clk) if (latch_clear) we_latch <= 1'b0;
   always @(posedge clk) if (pins_out.oe != 4'h0) oe_seen <= 1'b1;

   fidsr_core #(.MAKER_ID(MAKER), .MEM_TYPE(MTYPE), .CAPACITY(CAP), .DEVICE_ID(DEV),
      .ERASE_CYCLES(ERASE_CYCLES)) i_fidsr_core (.clk(clk), .rst(rst), .pins_in(pins_in),
      .pins_out(pins_out), .write_enable_latch_bit(we_latch), .otp_lock_bits(locks),
      .other_busy(other_busy), .erase_busy(erase_busy), .latch_clear(latch_clear),
      .table_addr(table_addr), .table_data(table_data));
   fidsr_host_model i_fidsr_host_model (.clk(clk), .pins_out(pins_out), .pins_in(pins_in),
      .rx_stb(rx_stb), .rx_byte(rx_byte));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic check(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   // ****************************************
   // Watcher: oldest note against each byte
   // ****************************************
   always @(posedge clk) begin
      if (rx_stb) check(expq.size() != 0 ? expq.pop_front() : 8'hxx, rx_byte);
   end

   task automatic rd(input int n, input int lanes);
      for (int i = 0; i < n; i++) i_fidsr_host_model.byte_io(8'h00, lanes, 1'b0, 1'b1);
      i_fidsr_host_model.stop();
   endtask

   // A frame refused for busy must never drive the pins
   task automatic ign(input logic [7:0] opc);
      oe_seen = 1'b0;
      i_fidsr_host_model.start();
      for (int i = 0; i < 7; i++) i_fidsr_host_model.byte_io(i == 0 ? opc : 8'h00, 1, 1'b1,
         1'b0);
      i_fidsr_host_model.stop();
      check(8'h00, {7'h00, oe_seen});
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      n_mismatch++;
      results();
   end

   initial begin
      logic [7:0] a;
      logic [7:0] d [3];
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      for (int f = 0; f < 2; f++) begin
         i_fidsr_host_model.start();
         i_fidsr_host_model.byte_io(fidsr_pkg::OPC_RD_IDENT, 1, 1'b1, 1'b0);
         expq = '{MAKER, MTYPE, CAP, MAKER};
         rd(4 - 2 * f, 1);
         expq.delete();
      end
      other_busy = 1'b1;
      ign(fidsr_pkg::OPC_RD_IDENT);
      other_busy = 1'b0;
      $display("test ident done");
      seed = xs(seed);
      a = seed[7:0];
      i_fidsr_host_model.head(fidsr_pkg::OPC_RD_TABLE, {16'h0000, a}, 1);
      i_fidsr_host_model.byte_io(8'h00, 1, 1'b1, 1'b0);
      expq = '{tbl(a), tbl(a + 8'h01)};
      rd(2, 1);
      $display("test table done");
      for (int r = 0; r < 5; r++) begin
         we_latch = (r != 0);
         i_fidsr_host_model.head(fidsr_pkg::OPC_SEC_ERASE,
            {8'h00, r < 2 ? 8'h10 : 8'(r - 1) << 4, 8'h00}, 1);
         if (r == 1) i_fidsr_host_model.byte_io(8'h00, 1, 1'b1, 1'b0);
         i_fidsr_host_model.stop();
         repeat (4) @(negedge clk);
         check({7'h00, r > 1}, {7'h00, erase_busy});
         if (r == 2) ign(fidsr_pkg::OPC_SEC_READ);
         for (int w = 0; w < ERASE_CYCLES + 50 && erase_busy; w++) @(negedge clk);
         // Let the status side apply the latch clear before looking at it
         @(negedge clk);
         check({6'h00, 1'b0, r == 1}, {6'h00, erase_busy, we_latch});
      end
      we_latch = 1'b1;
      i_fidsr_host_model.head(fidsr_pkg::OPC_SEC_PROG, {8'h00, fidsr_pkg::SEC_R2, 8'hFF}, 1);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         d[k] = seed[7:0];
         i_fidsr_host_model.byte_io(d[k], 1, 1'b1, 1'b0);
      end
      i_fidsr_host_model.stop();
      i_fidsr_host_model.head(fidsr_pkg::OPC_SEC_READ, {8'h00, fidsr_pkg::SEC_R2, 8'hFE}, 1);
      i_fidsr_host_model.byte_io(8'h00, 1, 1'b1, 1'b0);
      expq = '{8'hFF, d[0], d[1], d[2]};
      rd(4, 1);
      $display("test program done");
      locks = 3'b100;
      we_latch = 1'b1;
      // Locked register, then an address outside the map
      for (int q = 0; q < 2; q++) begin
         i_fidsr_host_model.head(fidsr_pkg::OPC_SEC_ERASE,
            {8'h00, q ? 8'h40 : fidsr_pkg::SEC_R3, 8'h00}, 1);
         i_fidsr_host_model.stop();
         check(8'h00, {7'h00, erase_busy});
      end
      i_fidsr_host_model.head(fidsr_pkg::OPC_SEC_PROG, {8'h00, fidsr_pkg::SEC_R3, 8'h00}, 1);
      i_fidsr_host_model.byte_io(8'h00, 1, 1'b1, 1'b0);
      i_fidsr_host_model.stop();
      i_fidsr_host_model.head(fidsr_pkg::OPC_SEC_READ, {8'h00, fidsr_pkg::SEC_R3, 8'h00}, 1);
      i_fidsr_host_model.byte_io(8'h00, 1, 1'b1, 1'b0);
      expq = '{8'hFF};
      rd(1, 1);
      we_latch = 1'b0;
      for (int s = 0; s < 2; s++) begin
         i_fidsr_host_model.head(fidsr_pkg::OPC_ID_DUAL, 24'(s), 2);
         i_fidsr_host_model.byte_io(8'hF0, 2, 1'b1, 1'b0);
         expq = s ? '{DEV, MAKER, DEV} : '{MAKER, DEV, MAKER};
         rd(3, 2);
      end
      i_fidsr_host_model.head(fidsr_pkg::OPC_ID_QUAD, 24'h000000, 4);
      i_fidsr_host_model.byte_io(8'hF0, 4, 1'b1, 1'b0);
      i_fidsr_host_model.byte_io(8'h00, 4, 1'b0, 1'b0);
      i_fidsr_host_model.byte_io(8'h00, 4, 1'b0, 1'b0);
      expq = '{MAKER, DEV, MAKER, DEV, MAKER};
      rd(5, 4);
      $display("test lanes done");
      results();
   end
endmodule

bind fidsr_core fidsr_core_assertions #(.ERASE_CYCLES(ERASE_CYCLES)) i_fidsr_core_assertions (
   .clk(clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out),
   .write_enable_latch_bit(write_enable_latch_bit), .otp_lock_bits(otp_lock_bits),
   .other_busy(other_busy), .erase_busy(erase_busy), .latch_clear(latch_clear),
   .table_addr(table_addr), .table_data(table_data));
`default_nettype wire

//--- fidsr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host serial controller model
// ****************************************
module fidsr_host_model (
   // Clock
   input wire logic clk,
   // Pins
   input wire fidsr_pkg::fidsr_pins_out_t pins_out,
   output fidsr_pkg::fidsr_pins_in_t pins_in,
   // Received bytes
   output logic rx_stb,
   output logic [7:0] rx_byte
);
   logic cs_n = 1'b1;
   logic sclk = 1'b0;
   logic [3:0] tx = 4'h0;
   logic [3:0] tx_oe = 4'h0;
   logic [3:0] junk = 4'h5;
   logic [3:0] io_w;
   initial rx_stb = 1'b0;
   // Released lanes toggle so a stale level never passes for data
   always @(negedge clk) junk <= ~junk;
   assign io_w = (pins_out.oe & pins_out.io) | (~pins_out.oe & tx_oe & tx)
      | (~pins_out.oe & ~tx_oe & junk);
   assign pins_in = {cs_n, sclk, io_w};

   task automatic byte_io(input logic [7:0] b, input int lanes, input logic drv,
      input logic chk);
      logic [7:0] r;
      logic [3:0] m;
      r = 8'h00;
      m = (4'h1 << lanes) - 4'h1;
      for (int i = 0; i < 8 / lanes; i++) begin
         @(negedge clk);
         sclk = 1'b0;
         tx_oe = drv ? m : 4'h0;
         tx = 4'(b >> (8 - lanes * (i + 1)));
         repeat (6) @(negedge clk);
         sclk = 1'b1;
         r = (r << lanes) | {4'h0, (lanes == 1) ? {3'h0, io_w[1]} : (io_w & m)};
         repeat (5) @(negedge clk);
      end
      if (chk) begin
         rx_byte = r;
         rx_stb = 1'b1;
         @(negedge clk);
         rx_stb = 1'b0;
      end
   endtask

   task automatic start();
      @(negedge clk);
      cs_n = 1'b0;
      repeat (6) @(negedge clk);
   endtask

   // Chip select rises after the last whole byte, once the serial clock has been back low for 6 clocks
   task automatic stop();
      repeat (6) @(negedge clk);
      sclk = 1'b0;
      tx_oe = 4'h0;
      repeat (6) @(negedge clk);
      cs_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask

   task automatic head(input logic [7:0] opc, input logic [23:0] a, input int lanes);
      start();
      byte_io(opc, 1, 1'b1, 1'b0);
      for (int k = 2; k >= 0; k--) byte_io(a[k*8 +: 8], lanes, 1'b1, 1'b0);
   endtask
endmodule
`default_nettype wire

//--- fidsr_pkg.sv
`default_nettype none
package fidsr_pkg;
   // ****************************************
   // Opcodes
   // ****************************************
   localparam logic [7:0] OPC_RD_IDENT = 8'h9F;
   localparam logic [7:0] OPC_RD_TABLE = 8'h5A;
   localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
   localparam logic [7:0] OPC_SEC_PROG = 8'h42;
   localparam logic [7:0] OPC_SEC_READ = 8'h48;
   localparam logic [7:0] OPC_ID_DUAL = 8'h92;
   localparam logic [7:0] OPC_ID_QUAD = 8'h94;

   // ****************************************
   // Rising-edge counts within a frame
   // ****************************************
   localparam logic [5:0] CNT_OPC = 6'h08;
   localparam logic [5:0] CNT_ADDR_SINGLE = 6'h20;
   localparam logic [5:0] CNT_ADDR_DUAL = 6'h18;
   localparam logic [5:0] CNT_ADDR_QUAD = 6'h10;
   localparam logic [5:0] CNT_OUT_LONG = 6'h28;
   localparam logic [5:0] CNT_OUT_QUAD = 6'h14;
   localparam logic [5:0] CNT_SAT = 6'h3F;

   // ****************************************
   // Security register map and values
   // ****************************************
   localparam logic [7:0] SEC_TOP = 8'h00;
   localparam logic [7:0] SEC_R1 = 8'h10;
   localparam logic [7:0] SEC_R2 = 8'h20;
   localparam logic [7:0] SEC_R3 = 8'h30;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] IDENT_LAST = 8'h02;
   localparam int SEC_REGS = 3;
   localparam int SEC_BYTES = 256;

   // ****************************************
   // Lanes
   // ****************************************
   localparam logic [3:0] LANES_1 = 4'h1;
   localparam logic [3:0] LANES_2 = 4'h2;
   localparam logic [3:0] LANES_4 = 4'h4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] OE_1 = 4'h2;
   localparam logic [3:0] OE_2 = 4'h3;
   localparam logic [3:0] OE_4 = 4'hF;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 250;
   localparam int ERASE_TIME_US = 50;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic [3:0] io;
   } fidsr_pins_in_t;

   typedef struct packed {
      logic [3:0] io;
      logic [3:0] oe;
   } fidsr_pins_out_t;

   typedef enum logic [2:0] {
      ST_OPC = 3'b000,
      ST_ADDR = 3'b001,
      ST_DATA = 3'b010,
      ST_PROG = 3'b011,
      ST_ERASE = 3'b100,
      ST_IGN = 3'b101
   } fidsr_state_t;
endpackage
`default_nettype wire
